// ### hw/swb_regs.svh
// timing counts and command codes of the single-wire slave link
`ifndef SWB_REGS_SVH
`define SWB_REGS_SVH
`define SWB_CLK_NS 8
// slot and reset/presence timing in ns, with cycle counts derived at 125 MHz
`define SWB_T_INIT_NS 40
`define SWB_T_SAMPLE_NS 120
`define SWB_T_THRESH_NS 240
`define SWB_T_HOLD_NS 240
`define SWB_T_W0_NS 480
`define SWB_T_SLOT_NS 600
`define SWB_T_REC_NS 80
`define SWB_T_RSTDET_NS 2400
`define SWB_T_RSTM_NS 3840
`define SWB_T_PDH_NS 120
`define SWB_T_PRES_NS 480
`define SWB_T_PSAMP_NS 320
`define SWB_T_RWAIT_NS 1200
`define SWB_UP(t) (10'((t + `SWB_CLK_NS - 1) / `SWB_CLK_NS))
`define SWB_DN(t) (10'((t) / `SWB_CLK_NS))
`define SWB_INIT_CYC `SWB_UP(`SWB_T_INIT_NS)
`define SWB_SAMPLE_CYC `SWB_DN(`SWB_T_SAMPLE_NS)
`define SWB_THRESH_CYC `SWB_UP(`SWB_T_THRESH_NS)
`define SWB_HOLD_CYC `SWB_UP(`SWB_T_HOLD_NS)
`define SWB_W0_CYC `SWB_UP(`SWB_T_W0_NS)
`define SWB_SLOT_CYC `SWB_UP(`SWB_T_SLOT_NS)
`define SWB_REC_CYC `SWB_UP(`SWB_T_REC_NS)
`define SWB_RSTDET_CYC `SWB_UP(`SWB_T_RSTDET_NS)
`define SWB_RSTM_CYC `SWB_UP(`SWB_T_RSTM_NS)
`define SWB_PDH_CYC `SWB_UP(`SWB_T_PDH_NS)
`define SWB_PRES_CYC `SWB_UP(`SWB_T_PRES_NS)
`define SWB_PSAMP_CYC `SWB_DN(`SWB_T_PSAMP_NS)
`define SWB_RWAIT_CYC `SWB_UP(`SWB_T_RWAIT_NS)
// identity and scratchpad sizes
`define SWB_ID_LAST 7'h3F
`define SWB_PAGES 8'h08
// command codes
`define SWB_CMD_READ_ID 8'h33
`define SWB_CMD_MATCH 8'h55
`define SWB_CMD_SKIP 8'hCC
`define SWB_CMD_SEARCH 8'hF0
`define SWB_CMD_WRITE_SP 8'h4E
`endif

// ### hw/swb_pkg.sv
// types shared by both ends of the single-wire link
package swb_pkg;
   typedef enum logic [1:0] {SK_RESET, SK_WRITE, SK_READ, SK_TRIPLET}
      swb_kind_t;
   typedef enum logic [3:0] {SD_HALT, SD_PRES, SD_ROM_CMD, SD_READ_ID,
      SD_MATCH, SD_SEARCH, SD_MEM_CMD, SD_PAGE, SD_WDATA} swb_dev_st_t;
   typedef enum logic [2:0] {SM_IDLE, SM_RST_LOW, SM_RST_WAIT, SM_SLOT,
      SM_REC} swb_mst_st_t;
   typedef struct packed {
      swb_dev_st_t st;
      logic sync0;
      logic sync1;
      logic line_d;
      logic [9:0] lowcnt;
      logic [9:0] drv;
      logic [9:0] wt;
      logic oe;
      logic [6:0] bcnt;
      logic [1:0] phase;
      logic [7:0] sh;
      logic miss;
      logic [2:0] page;
      logic [3:0] off;
      logic [63:0][7:0] sp;
      logic [7:0] rd_data;
      logic sel;
      logic wr_stb;
   } swb_dev_reg_t;
   typedef struct packed {
      swb_mst_st_t st;
      logic sync0;
      logic sync1;
      logic [9:0] cnt;
      logic oe;
      logic [1:0][9:0] fq;
      logic [1:0] fcnt;
      logic rdy;
      swb_kind_t kind;
      logic [7:0] sh;
      logic [2:0] bidx;
      logic [1:0] rb;
      logic wbit;
      logic samp;
      logic rsp_valid;
      logic [7:0] rsp_data;
   } swb_mst_reg_t;
endpackage

// ### hw/swb_link_if.sv
// open-drain single-wire link joining the slave and the master
`timescale 1ns/1ps
interface swb_link_if;
   logic dev_out;
   logic dev_oe;
   logic mst_out;
   logic mst_oe;
   logic line;
   // wired-AND with pull-up: released line rests high (R1)
   assign line = (dev_oe ? dev_out : 1'b1) & (mst_oe ? mst_out : 1'b1);
   modport dev (input line, output dev_out, output dev_oe);
   modport mst (input line, output mst_out, output mst_oe);
endinterface

// ### hw/swb_dev.sv
// slave end: reset/presence, identity commands, scratchpad write
// Link rules, for slave and master
// (R1) idle line rests high; resume only then
// (R2) unlimited high gap between bits keeps state
// (R3) long low is reset; transaction abandoned
// (R4) order: init, identity cmd, memory cmd, data
// (R5) master reset pulse answered by presence pulse
// (R6) identity command received as eight bits
// (R7) 33h sends family, serial, check byte
// (R8) master uses 33h with single slave only
// (R9) open-drain: zero pulls low, one releases
// (R10) 55h: exact 64-bit match selects, else wait
// (R11) CCh goes straight to memory command
// (R12) F0h: send bit, complement, take master bit
// (R13) search: differing bit deselects for the pass
// (R14) master decodes search read pairs
// (R15) search repeats per bit, LSB first
// (R16) 4Eh, page byte, writes from offset zero
// (R17) page byte precedes data bytes
// (R18) pages 00h to 07h only
// (R19) reset ends write, received bytes kept
// (R20) unknown code or bad page: wait reset
`timescale 1ns/1ps
`include "swb_regs.svh"
module swb_dev (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // link
   swb_link_if.dev link,
   // identity, supplied by user logic on this clock
   input wire logic [63:0] id_in,
   // scratchpad read-back
   input wire logic [5:0] sp_addr_in,
   output logic [7:0] sp_data_out,
   // status
   output logic sel_out,
   output logic wr_stb_out
);
   swb_pkg::swb_dev_reg_t r;
   swb_pkg::swb_dev_reg_t n;
   logic fall;
   logic rise;
   logic rxbit;
   logic txbit;
   logic txslot;
   logic bytedone;
   logic [7:0] nb;

   // next state of the whole slave
   always_comb begin
      n = r;
      n.sync0 = link.line;
      n.sync1 = r.sync0;
      n.line_d = r.sync1;
      n.wr_stb = 1'b0;
      n.rd_data = r.sp[sp_addr_in];
      fall = r.line_d & ~r.sync1;
      rise = ~r.line_d & r.sync1;
      rxbit = (r.lowcnt < `SWB_THRESH_CYC);
      nb = {rxbit, r.sh[7:1]};
      bytedone = (r.bcnt[2:0] == 3'h7);
      txslot = (r.st == swb_pkg::SD_READ_ID) ||
         (r.st == swb_pkg::SD_SEARCH && r.phase != 2'h2);
      txbit = id_in[r.bcnt[5:0]] ^ (r.phase == 2'h1); // R12
      // own pull-down countdown
      if (r.drv != 10'h000) begin
         n.drv = r.drv - 10'h001;
      end
      // low-time meter; any high time is fine (R2)
      if (fall) begin
         n.lowcnt = 10'h001;
      end else if (~r.sync1 && r.lowcnt != `SWB_RSTDET_CYC) begin
         n.lowcnt = r.lowcnt + 10'h001;
      end
      // zero bit pulls low, one bit leaves line released
      if (fall && txslot && ~txbit) begin
         n.drv = `SWB_HOLD_CYC; // R9
      end
      // presence delay after reset release
      if (r.wt != 10'h000) begin
         n.wt = r.wt - 10'h001;
         if (r.wt == 10'h001) begin
            n.drv = `SWB_PRES_CYC; // R5
         end
      end
      // slot completion on rising edge
      if (rise) begin
         case (r.st)
            swb_pkg::SD_PRES: begin
               if (r.lowcnt == `SWB_RSTDET_CYC) begin
                  n.wt = `SWB_PDH_CYC; // R5
               end else begin
                  n.st = swb_pkg::SD_ROM_CMD; // R4
                  n.bcnt = 7'h00;
               end
            end
            swb_pkg::SD_ROM_CMD: begin
               n.sh = nb; // R6
               n.bcnt = r.bcnt + 7'h01;
               if (bytedone) begin
                  n.bcnt = 7'h00;
                  n.phase = 2'h0;
                  n.miss = 1'b0;
                  case (nb)
                     `SWB_CMD_READ_ID: n.st = swb_pkg::SD_READ_ID; // R7
                     `SWB_CMD_MATCH: n.st = swb_pkg::SD_MATCH; // R10
                     `SWB_CMD_SEARCH: n.st = swb_pkg::SD_SEARCH; // R12
                     `SWB_CMD_SKIP: begin
                        n.st = swb_pkg::SD_MEM_CMD; // R11
                        n.sel = 1'b1;
                     end
                     default: n.st = swb_pkg::SD_HALT; // R20
                  endcase
               end
            end
            swb_pkg::SD_READ_ID: begin
               n.bcnt = r.bcnt + 7'h01; // R7
               if (r.bcnt == `SWB_ID_LAST) begin
                  n.bcnt = 7'h00;
                  n.st = swb_pkg::SD_MEM_CMD;
                  n.sel = 1'b1;
               end
            end
            swb_pkg::SD_MATCH: begin
               n.miss = r.miss | (rxbit != id_in[r.bcnt[5:0]]);
               n.bcnt = r.bcnt + 7'h01;
               if (r.bcnt == `SWB_ID_LAST) begin
                  n.bcnt = 7'h00;
                  if (n.miss) begin
                     n.st = swb_pkg::SD_HALT; // R10
                  end else begin
                     n.st = swb_pkg::SD_MEM_CMD; // R10
                     n.sel = 1'b1;
                  end
               end
            end
            swb_pkg::SD_SEARCH: begin
               if (r.phase != 2'h2) begin
                  n.phase = r.phase + 2'h1; // R12
               end else if (rxbit != id_in[r.bcnt[5:0]]) begin
                  n.st = swb_pkg::SD_HALT; // R13
               end else begin
                  n.phase = 2'h0;
                  n.bcnt = r.bcnt + 7'h01; // R15
                  if (r.bcnt == `SWB_ID_LAST) begin
                     n.bcnt = 7'h00;
                     n.st = swb_pkg::SD_MEM_CMD;
                     n.sel = 1'b1;
                  end
               end
            end
            swb_pkg::SD_MEM_CMD: begin
               n.sh = nb;
               n.bcnt = r.bcnt + 7'h01;
               if (bytedone) begin
                  n.bcnt = 7'h00;
                  if (nb == `SWB_CMD_WRITE_SP) begin
                     n.st = swb_pkg::SD_PAGE; // R16
                  end else begin
                     n.st = swb_pkg::SD_HALT; // R20
                  end
               end
            end
            swb_pkg::SD_PAGE: begin
               n.sh = nb;
               n.bcnt = r.bcnt + 7'h01;
               if (bytedone) begin
                  n.bcnt = 7'h00;
                  n.off = 4'h0; // R16
                  n.page = nb[2:0];
                  if (nb < `SWB_PAGES) begin
                     n.st = swb_pkg::SD_WDATA; // R18
                  end else begin
                     n.st = swb_pkg::SD_HALT; // R20
                  end
               end
            end
            swb_pkg::SD_WDATA: begin
               n.sh = nb;
               n.bcnt = r.bcnt + 7'h01;
               if (bytedone) begin
                  n.bcnt = 7'h00;
                  n.sp[{r.page, r.off[2:0]}] = nb; // R16
                  n.wr_stb = 1'b1;
                  n.off = r.off + 4'h1;
                  if (r.off == 4'h7) begin
                     n.st = swb_pkg::SD_HALT;
                  end
               end
            end
            swb_pkg::SD_HALT: n.st = swb_pkg::SD_HALT;
            default: n.st = swb_pkg::SD_HALT;
         endcase
      end
      // long low wins over all: drop transaction, keep scratchpad
      if (~r.sync1 && r.lowcnt == `SWB_RSTDET_CYC - 10'h001) begin
         n.st = swb_pkg::SD_PRES; // R3
         n.drv = 10'h000; // R19
         n.wt = 10'h000;
         n.sel = 1'b0;
         n.bcnt = 7'h00;
      end
      n.oe = (n.drv != 10'h000);
   end

   // state register
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r <= '0;
         r.st <= swb_pkg::SD_HALT;
         r.sync0 <= 1'b1;
         r.sync1 <= 1'b1;
         r.line_d <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // outputs straight from the state register, except dev_out which is tied to zero
   assign link.dev_out = 1'b0;
   assign link.dev_oe = r.oe;
   assign sp_data_out = r.rd_data;
   assign sel_out = r.sel;
   assign wr_stb_out = r.wr_stb;
endmodule

// ### hw/swb_mst.sv
// master end: command buffer and bit-slot engine for the link
`timescale 1ns/1ps
`include "swb_regs.svh"
module swb_mst (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // link
   swb_link_if.mst link,
   // command stream
   input wire logic cmd_valid_in,
   input wire swb_pkg::swb_kind_t cmd_kind_in,
   input wire logic [7:0] cmd_data_in,
   output logic cmd_ready_out,
   // answer stream
   output logic rsp_valid_out,
   output logic [7:0] rsp_data_out
);
   swb_pkg::swb_mst_reg_t r;
   swb_pkg::swb_mst_reg_t n;
   logic pop;
   logic last;
   logic [1:0] fc;

   // value driven in the coming slot; one means release early
   function automatic logic slot_bit(input swb_pkg::swb_kind_t k,
      input logic [7:0] sh, input logic [2:0] bi, input logic [1:0] rb);
      logic b;
      b = 1'b1;
      if (k == swb_pkg::SK_WRITE) begin
         b = sh[0];
      end else if (k == swb_pkg::SK_TRIPLET && bi == 3'h2) begin
         b = (rb == 2'b00) ? sh[0] : rb[0]; // R14
      end
      return b;
   endfunction

   // next state of buffer and engine
   always_comb begin
      n = r;
      n.sync0 = link.line;
      n.sync1 = r.sync0;
      n.rsp_valid = 1'b0;
      n.cnt = r.cnt + 10'h001;
      pop = 1'b0;
      last = (r.kind == swb_pkg::SK_TRIPLET) ? (r.bidx == 3'h2) :
         (r.bidx == 3'h7);
      case (r.st)
         swb_pkg::SM_IDLE: begin
            if (r.fcnt != 2'h0) begin
               pop = 1'b1;
               n.kind = swb_pkg::swb_kind_t'(r.fq[0][9:8]);
               n.sh = r.fq[0][7:0];
               n.bidx = 3'h0;
               n.rb = 2'b00;
               n.cnt = 10'h000;
               n.oe = 1'b1;
               if (n.kind == swb_pkg::SK_RESET) begin
                  n.st = swb_pkg::SM_RST_LOW; // R5
               end else begin
                  n.st = swb_pkg::SM_SLOT;
                  n.wbit = slot_bit(n.kind, n.sh, 3'h0, 2'b00);
               end
            end
         end
         swb_pkg::SM_RST_LOW: begin
            if (r.cnt == `SWB_RSTM_CYC) begin
               n.oe = 1'b0;
               n.cnt = 10'h000;
               n.st = swb_pkg::SM_RST_WAIT;
            end
         end
         swb_pkg::SM_RST_WAIT: begin
            if (r.cnt == `SWB_PSAMP_CYC) begin
               n.samp = ~r.sync1; // R5
            end
            if (r.cnt == `SWB_RWAIT_CYC) begin
               n.rsp_valid = 1'b1;
               n.rsp_data = {7'h00, r.samp};
               n.st = swb_pkg::SM_IDLE;
            end
         end
         swb_pkg::SM_SLOT: begin
            if (r.cnt == (r.wbit ? `SWB_INIT_CYC : `SWB_W0_CYC)) begin
               n.oe = 1'b0;
            end
            if (r.cnt == `SWB_SAMPLE_CYC) begin
               n.samp = r.sync1;
            end
            // slot ends once its time is up and the line is back high
            if (r.cnt >= `SWB_SLOT_CYC && r.sync1) begin
               n.cnt = 10'h000;
               n.st = swb_pkg::SM_REC; // R1
               if (r.kind == swb_pkg::SK_READ) begin
                  n.sh = {r.samp, r.sh[7:1]};
               end else if (r.kind == swb_pkg::SK_WRITE) begin
                  n.sh = {1'b0, r.sh[7:1]};
               end else if (r.bidx != 3'h2) begin
                  n.rb[r.bidx[0]] = r.samp; // R12
               end
            end
         end
         swb_pkg::SM_REC: begin
            if (r.cnt == `SWB_REC_CYC) begin
               n.cnt = 10'h000;
               n.bidx = r.bidx + 3'h1;
               if (last) begin
                  n.rsp_valid = 1'b1;
                  n.rsp_data = (r.kind == swb_pkg::SK_TRIPLET) ?
                     {5'h00, r.wbit, r.rb} : r.sh;
                  n.st = swb_pkg::SM_IDLE;
               end else begin
                  n.oe = 1'b1;
                  n.st = swb_pkg::SM_SLOT;
                  n.wbit = slot_bit(r.kind, r.sh, n.bidx, r.rb);
               end
            end
         end
         default: n.st = swb_pkg::SM_IDLE;
      endcase
      // two-entry buffer: pop head, then append
      fc = r.fcnt;
      if (pop) begin
         n.fq[0] = r.fq[1];
         fc = r.fcnt - 2'h1;
      end
      if (cmd_valid_in && r.rdy) begin
         n.fq[fc[0]] = {cmd_kind_in, cmd_data_in};
         fc = fc + 2'h1;
      end
      n.fcnt = fc;
      n.rdy = (fc != 2'h2);
   end

   // state register
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r <= '0;
         r.st <= swb_pkg::SM_IDLE;
         r.sync0 <= 1'b1;
         r.sync1 <= 1'b1;
         r.rdy <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // outputs straight from the state register, except mst_out which is tied to zero
   assign link.mst_out = 1'b0;
   assign link.mst_oe = r.oe;
   assign cmd_ready_out = r.rdy;
   assign rsp_valid_out = r.rsp_valid;
   assign rsp_data_out = r.rsp_data;
endmodule

// ### sim/swb_link_chk.sv
// link checker: wire-level relations between slave and master ends
`timescale 1ns/1ps
module swb_link_chk (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // link signals
   input wire logic dev_out,
   input wire logic dev_oe,
   input wire logic mst_out,
   input wire logic mst_oe,
   input wire logic line
);
   logic [9:0] mst_run;
   logic [9:0] dev_run;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);

   // run lengths of each party's pull-down, saturating
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mst_run <= 10'h000;
         dev_run <= 10'h000;
      end else begin
         mst_run <= mst_oe ? (mst_run == 10'h3FF ? mst_run : mst_run + 10'h001)
            : 10'h000;
         dev_run <= dev_oe ? (dev_run == 10'h3FF ? dev_run : dev_run + 10'h001)
            : 10'h000;
      end
   end

   line_idle_high_a: assert property (!dev_oe && !mst_oe |-> line)
      else $error("line not high while released");
   dev_pull_only_a: assert property (dev_oe |-> !dev_out && !line)
      else $error("slave drives a high level");
   mst_pull_only_a: assert property (mst_oe |-> !mst_out && !line)
      else $error("master drives a high level");
   start_released_a: assert property (
      $rose(rstn_in) |-> !dev_oe && !mst_oe)
      else $error("pull-down active right after reset");
   bus_reset_quiet_a: assert property (mst_run > 10'h136 |-> !dev_oe)
      else $error("slave drives during bus reset");
   presence_after_a: assert property (
      $fell(mst_oe) && $past(mst_run) >= 10'h12C |-> ##[1:40] dev_oe)
      else $error("no presence after bus reset");
   presence_hold_a: assert property ($rose(dev_oe) |-> dev_oe [*8])
      else $error("slave pull-down too short");
   dev_run_bound_a: assert property (dev_run <= 10'h046)
      else $error("slave holds line low too long");
   mst_slot_min_a: assert property ($rose(mst_oe) |-> mst_oe [*4])
      else $error("master slot pulse too short");

   // main scenarios seen on the wire
   rst_c: cover property ($fell(mst_oe) && $past(mst_run) >= 10'h12C);
   pres_c: cover property ($rose(dev_oe) && !mst_oe);
   read0_c: cover property (dev_oe && mst_oe);
endmodule

// ### sim/single_wire_slave_rom_layer_tb.sv
// testbench: slave and master ends joined over the link
`timescale 1ns/1ps
module single_wire_slave_rom_layer_tb;
   // arbitrary identity value
   localparam logic [63:0] ID = 64'h5A3C_960F_1E2D_4B17;
   logic sys_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic cmd_valid = 1'b0;
   swb_pkg::swb_kind_t cmd_kind = swb_pkg::SK_WRITE;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ready;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic [5:0] sp_addr = 6'h00;
   logic [7:0] sp_data;
   logic sel;
   logic wr_stb;
   logic [7:0] r;
   int mismatches = 0;
   int n_checks = 0;
   int n_wr = 0;
   int base;

   swb_link_if link();
   swb_dev i_swb_dev (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .link(link.dev), .id_in(ID), .sp_addr_in(sp_addr),
      .sp_data_out(sp_data), .sel_out(sel), .wr_stb_out(wr_stb));
   swb_mst i_swb_mst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .link(link.mst), .cmd_valid_in(cmd_valid), .cmd_kind_in(cmd_kind),
      .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
      .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data));
   swb_link_chk i_swb_link_chk (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .dev_out(link.dev_out), .dev_oe(link.dev_oe), .mst_out(link.mst_out),
      .mst_oe(link.mst_oe), .line(link.line));

   // clock at 125 MHz
   initial begin
      forever #4 sys_clk_in = ~sys_clk_in;
   end

   // count scratchpad stores
   always @(posedge sys_clk_in) begin
      if (wr_stb === 1'b1) n_wr++;
   end

   // compare one value
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one command through the buffer, wait for its answer
   task automatic op(input swb_pkg::swb_kind_t k, input logic [7:0] d);
      int n;
      n = 0;
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_data = d;
      while (cmd_ready !== 1'b1 && n < 2000) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      if (n >= 2000) chk(8'hEE, 8'h00);
      @(posedge sys_clk_in);
      #1;
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20000) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      if (n >= 20000) chk(8'hEE, 8'h00);
      r = rsp_data;
   endtask

   // bus reset, presence, identity command
   task automatic start(input logic [7:0] rom);
      op(swb_pkg::SK_RESET, 8'h00);
      chk(r, 8'h01);
      op(swb_pkg::SK_WRITE, rom);
      chk(r, 8'h00);
      base = n_wr;
   endtask

   // count stores since start, after the last one has landed
   task automatic stores(input logic [7:0] exp);
      repeat (20) @(posedge sys_clk_in);
      #1;
      chk(8'(n_wr - base), exp);
   endtask

   // read back one scratchpad byte
   task automatic sp_chk(input logic [5:0] a, input logic [7:0] e);
      sp_addr = a;
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk(sp_data, e);
   endtask

   task automatic t_read_id;
      start(8'h33);
      for (int i = 0; i < 8; i++) begin
         op(swb_pkg::SK_READ, 8'h00);
         chk(r, ID[8*i +: 8]);
      end
      chk({7'h00, sel}, 8'h01);
   endtask

   task automatic t_skip_write;
      start(8'hCC);
      repeat (2000) @(posedge sys_clk_in);
      #1;
      op(swb_pkg::SK_WRITE, 8'h4E);
      op(swb_pkg::SK_WRITE, 8'h03);
      op(swb_pkg::SK_WRITE, 8'hA1);
      op(swb_pkg::SK_WRITE, 8'hB2);
      op(swb_pkg::SK_WRITE, 8'hC3);
      op(swb_pkg::SK_RESET, 8'h00);
      stores(8'h03);
      chk({7'h00, sel}, 8'h00);
      sp_chk(6'd24, 8'hA1);
      sp_chk(6'd25, 8'hB2);
      sp_chk(6'd26, 8'hC3);
      sp_chk(6'd27, 8'h00);
   endtask

   task automatic t_full_page;
      start(8'hCC);
      op(swb_pkg::SK_WRITE, 8'h4E);
      op(swb_pkg::SK_WRITE, 8'h07);
      for (int k = 0; k < 9; k++) op(swb_pkg::SK_WRITE, 8'h10 + 8'(k));
      stores(8'h08);
      for (int k = 0; k < 8; k++) sp_chk(6'd56 + 6'(k), 8'h10 + 8'(k));
   endtask

   task automatic t_refused;
      start(8'hCC);
      op(swb_pkg::SK_WRITE, 8'h4E);
      op(swb_pkg::SK_WRITE, 8'h08);
      op(swb_pkg::SK_WRITE, 8'h55);
      stores(8'h00);
      start(8'hAA);
      op(swb_pkg::SK_WRITE, 8'h4E);
      op(swb_pkg::SK_WRITE, 8'h00);
      op(swb_pkg::SK_WRITE, 8'h77);
      stores(8'h00);
      start(8'hCC);
      op(swb_pkg::SK_WRITE, 8'h48);
      op(swb_pkg::SK_WRITE, 8'h00);
      op(swb_pkg::SK_WRITE, 8'h99);
      stores(8'h00);
      sp_chk(6'h00, 8'h00);
   endtask

   // match with own identity, then with one bit wrong
   task automatic t_match(input logic [63:0] id, input logic hit);
      start(8'h55);
      for (int i = 0; i < 8; i++) op(swb_pkg::SK_WRITE, id[8*i +: 8]);
      chk({7'h00, sel}, {7'h00, hit});
      op(swb_pkg::SK_WRITE, 8'h4E);
      op(swb_pkg::SK_WRITE, 8'h01);
      op(swb_pkg::SK_WRITE, hit ? 8'h5A : 8'h66);
      stores({7'h00, hit});
      sp_chk(6'd8, 8'h5A);
   endtask

   task automatic t_search;
      start(8'hF0);
      for (int i = 0; i < 64; i++) begin
         op(swb_pkg::SK_TRIPLET, 8'h00);
         chk(r, {5'h00, ID[i], ~ID[i], ID[i]});
      end
      chk({7'h00, sel}, 8'h01);
      // third slot writes the inverse of own bit 0, so the slave drops out
      start(8'hF0);
      op(swb_pkg::SK_WRITE, {5'h00, ~ID[0], 2'h3});
      op(swb_pkg::SK_TRIPLET, 8'h00);
      chk(r, 8'h07);
      chk({7'h00, sel}, 8'h00);
   endtask

   // summary and verdict
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (90000) @(posedge sys_clk_in);
      mismatches++;
      wrap_up;
   end

   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk_in);
      #1;
      rstn_in = 1'b1;
      chk({6'h00, cmd_ready, rsp_valid}, 8'h02);
      t_read_id;
      t_skip_write;
      t_full_page;
      t_refused;
      t_match(ID, 1'b1);
      t_match(ID ^ 64'h8000_0000_0000_0000, 1'b0);
      t_search;
      wrap_up;
   end
endmodule
